// ### verilog/bsr_device.sv
/*
 * buffered serial receiver device end: stores input bytes, resends
 * them over the shared link on request.
 * assumes host and device clocks run at the same nominal rate.
 */
//
// Overview of operation
// RL1: buffer holds up to 32 received bytes
// RL2: host high pulse requests buffered bytes
// RL3: input rate 9600, 4800, 2400 or 1200
// RL4: input bit timing scales with the clock
// RL5: input polarity selectable, inverted or not
// RL6: link bytes at 9600, open drain only
// RL7: falling edge of request pulse starts sending
// RL8: link frame is inverted 8N1 at 9600
// RL9: single byte or burst per request
// RL10: match mode drops bytes until match byte
// RL11: optional break before match is armed
// RL12: empty output and active low ready output
// RL13: long pulse then config and match byte
// RL14: host waits 100 ms before requests
// RL15: bytes resent in arrival order
// RL16: full drops new bytes; empty request ignored
`timescale 1ns/1ns
`include "bsr_regs.svh"
module bsr_device
	import bsr_pkg::*;
#(
	parameter int DEPTH        = `BSR_DEPTH,
	parameter int INIT_DET_CYC = `BSR_INIT_DET_CYC
) (
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	bsr_link_if.dev   link,
	input  wire logic ser_rx_i,
	output logic      buf_empty_o,
	output logic      buf_rdy_n_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int HW = $clog2(INIT_DET_CYC + 1);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
	localparam logic [HW-1:0] DET = HW'(INIT_DET_CYC - 1);
	localparam logic [15:0] LDIV = 16'(`BSR_LINK_DIV);
	typedef struct packed {
		bsr_dev_st_t              st;
		logic                     ls1;
		logic                     ls2;
		logic                     lprev;
		logic [HW-1:0]            hi_cnt;
		logic [7:0]               cfg;
		logic [7:0]               mbyte;
		logic                     armed;
		logic                     matched;
		logic [DEPTH-1:0][7:0]    mem;
		logic [AW-1:0]            wp;
		logic [AW-1:0]            rp;
		logic [AW:0]              cnt;
		logic [10:0]              tx_sh;
		logic [3:0]               tx_nb;
		logic [15:0]              tx_div;
		logic                     oe;
		logic                     out;
		logic                     empty;
		logic                     rdy_n;
	} bsr_dev_s_t;
	localparam bsr_dev_s_t RST = '{st: DV_RUN, empty: 1'b1, default: '0};
	bsr_dev_s_t q, d;
	logic [7:0]  in_data;
	logic        in_valid;
	logic        in_brk;
	logic [7:0]  lk_data;
	logic        lk_valid;
	logic        push;
	logic        pop;
	// slower clock stretches every bit, so rates scale with it [RL4]
	function automatic logic [15:0] rate_div(input logic [1:0] sel);
		return LDIV << sel; // [RL3]
	endfunction : rate_div
	////////////////////////////////////////////////////////////////////////
	bsr_uart_rx u_in_rx (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.rx_i      (ser_rx_i),
		.invert_i  (q.cfg[`BSR_CFG_INV]), // [RL5]
		.div_i     (rate_div(q.cfg[`BSR_CFG_RATE])),
		.data_o    (in_data),
		.valid_o   (in_valid),
		.brk_o     (in_brk)
	);
	// config bytes arrive inverted at 9600 like all link traffic [RL8]
	// held in reset outside config so the init pulse is not framed
	bsr_uart_rx u_lk_rx (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i && (q.st == DV_CFG || q.st == DV_MATCH)),
		.rx_i      (link.line),
		.invert_i  (1'b1),
		.div_i     (LDIV),
		.data_o    (lk_data),
		.valid_o   (lk_valid),
		.brk_o     ()
	);
	////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.ls1 = link.line;
		d.ls2 = q.ls1;
		d.lprev = q.ls2;
		d.out = 1'b1;
		pop = 1'b0;
		d.hi_cnt = q.ls2 ? q.hi_cnt + HW'(q.hi_cnt != DET) : '0;
		// match filter; the match byte itself is not stored
		if (in_brk && q.cfg[`BSR_CFG_BRK]) d.armed = 1'b1; // [RL11]
		if (in_valid && q.cfg[`BSR_CFG_MATCH] && !q.matched &&
		    (q.armed || !q.cfg[`BSR_CFG_BRK]) && in_data == q.mbyte)
			d.matched = 1'b1; // [RL10]
		push = in_valid && (q.matched || !q.cfg[`BSR_CFG_MATCH]);
		push = push && (q.cnt != FULL); // [RL16]
		if (push) begin
			d.mem[q.wp] = in_data; // [RL1]
			d.wp = q.wp + AW'(1);
		end
		unique case (q.st)
			DV_RUN: begin
				if (q.ls2 && q.hi_cnt == DET) d.st = DV_INIT; // [RL13]
				else if (q.lprev && !q.ls2 && q.cnt != '0) // [RL7] [RL16]
					pop = 1'b1; // [RL2]
			end
			DV_INIT: if (!q.ls2) d.st = DV_CFG;
			DV_CFG: if (lk_valid) begin
				d.cfg = lk_data; // [RL13]
				d.st = lk_data[`BSR_CFG_MATCH] ? DV_MATCH : DV_RUN;
			end
			DV_MATCH: if (lk_valid) begin
				d.mbyte = lk_data;
				d.st = DV_RUN;
			end
			DV_TX: if (q.tx_div == 16'h0000) begin
				d.tx_div = LDIV - 16'h0001; // [RL6]
				d.tx_sh = q.tx_sh >> 1;
				d.tx_nb = q.tx_nb - 4'h1;
				if (q.tx_nb == 4'h0) begin
					d.st = DV_RUN;
					pop = q.cfg[`BSR_CFG_BURST] && q.cnt != '0; // [RL9]
				end
			end else d.tx_div = q.tx_div - 16'h0001;
		endcase
		if (pop) begin
			// one idle bit ahead of the start bit lets the host turn round
			d.tx_sh = {bsr_frame(q.mem[q.rp]), 1'b0}; // [RL15] [RL8]
			d.tx_nb = 4'hA;
			d.tx_div = LDIV - 16'h0001;
			d.rp = q.rp + AW'(1);
			d.st = DV_TX;
		end
		d.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
		if (q.st == DV_CFG && lk_valid) begin
			// new configuration restarts buffering from scratch
			d.wp = '0;
			d.rp = '0;
			d.cnt = '0;
			d.armed = 1'b0;
			d.matched = 1'b0;
		end
		// only ever drives high; the pull-down makes the low level [RL6]
		d.oe = (d.st == DV_TX) && d.tx_sh[0];
		d.empty = (d.cnt == '0); // [RL12]
		d.rdy_n = (d.cnt == FULL); // [RL12]
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) q <= RST;
		else q <= d;
	end
	////////////////////////////////////////////////////////////////////////
	assign link.dev_oe = q.oe;
	assign link.dev_out = q.out;
	assign buf_empty_o = q.empty;
	assign buf_rdy_n_o = q.rdy_n;
endmodule : bsr_device

// ### inc/bsr_regs.svh
/*
 * constants of the buffered serial receiver link and its host registers.
 * assumes the 10 MHz system clock on both ends.
 */
`ifndef BSR_REGS_SVH
`define BSR_REGS_SVH
`define BSR_CLK_HZ        10000000
`define BSR_LINK_BAUD     9600
`define BSR_LINK_DIV      (`BSR_CLK_HZ / `BSR_LINK_BAUD)
`define BSR_INIT_HOLD_MS  10
`define BSR_INIT_HOLD_CYC (`BSR_INIT_HOLD_MS * (`BSR_CLK_HZ / 1000))
`define BSR_INIT_DET_MS   5
`define BSR_INIT_DET_CYC  (`BSR_INIT_DET_MS * (`BSR_CLK_HZ / 1000))
`define BSR_SETTLE_MS     100
`define BSR_SETTLE_CYC    (`BSR_SETTLE_MS * (`BSR_CLK_HZ / 1000))
`define BSR_REQ_PULSE_US  20
`define BSR_REQ_PULSE_CYC (`BSR_REQ_PULSE_US * (`BSR_CLK_HZ / 1000000))
`define BSR_DEPTH         32
`define BSR_CFG_INV       0
`define BSR_CFG_RATE      2:1
`define BSR_CFG_BURST     3
`define BSR_CFG_MATCH     4
`define BSR_CFG_BRK       5
`define BSR_REG_CTRL      8'h00
`define BSR_REG_CFG       8'h04
`define BSR_REG_STAT      8'h08
`define BSR_REG_RXDATA    8'h0C
`define BSR_REG_IRQ_STAT  8'h10
`define BSR_REG_IRQ_MASK  8'h14
`define BSR_CTRL_INIT     0
`define BSR_CTRL_REQ      1
`define BSR_IRQ_RX        0
`define BSR_IRQ_INIT      1
`endif

// ### inc/bsr_pkg.sv
/*
 * types shared by both ends of the buffered serial receiver.
 * assumes bsr_regs.svh on the include path.
 */
`include "bsr_regs.svh"
package bsr_pkg;
	typedef enum logic [3:0] {
		RX_IDLE  = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA  = 4'b0100,
		RX_STOP  = 4'b1000
	} bsr_rx_st_t;
	typedef enum logic [4:0] {
		DV_RUN   = 5'b00001,
		DV_INIT  = 5'b00010,
		DV_CFG   = 5'b00100,
		DV_MATCH = 5'b01000,
		DV_TX    = 5'b10000
	} bsr_dev_st_t;
	typedef enum logic [4:0] {
		HS_IDLE = 5'b00001,
		HS_INIT = 5'b00010,
		HS_SEND = 5'b00100,
		HS_WAIT = 5'b01000,
		HS_REQ  = 5'b10000
	} bsr_host_st_t;
	// drive pattern lsb first: start high, inverted data, stop low
	function automatic logic [9:0] bsr_frame(input logic [7:0] b);
		return {1'b0, ~b, 1'b1};
	endfunction : bsr_frame
endpackage : bsr_pkg

// ### inc/bsr_link_if.sv
/*
 * single wire link between host and buffer device.
 * assumes a pull-down: the line is high only while a party drives it.
 */
`timescale 1ns/1ns
interface bsr_link_if;
	logic host_out;
	logic host_oe;
	logic dev_out;
	logic dev_oe;
	logic line;
	assign line = (host_out & host_oe) | (dev_out & dev_oe);
	modport host (output host_out, output host_oe, input line);
	modport dev  (output dev_out, output dev_oe, input line);
endinterface : bsr_link_if

// ### verilog/bsr_uart_rx.sv
/*
 * 8n1 serial receiver with selectable polarity and bit period.
 * assumes rx_i is asynchronous; div_i stable while a frame is received.
 */
`timescale 1ns/1ns
`include "bsr_regs.svh"
module bsr_uart_rx
	import bsr_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic        rx_i,
	input  wire logic        invert_i,
	input  wire logic [15:0] div_i,
	output logic      [7:0]  data_o,
	output logic             valid_o,
	output logic             brk_o
);
	typedef struct packed {
		bsr_rx_st_t  st;
		logic        s1;
		logic        s2;
		logic        prev;
		logic [15:0] cnt;
		logic [2:0]  nb;
		logic [7:0]  sh;
		logic [7:0]  data;
		logic        valid;
		logic        brk;
	} bsr_rx_s_t;
	localparam bsr_rx_s_t RST = '{st: RX_IDLE, default: '0};
	bsr_rx_s_t q, d;
	logic      l;
	////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.s1 = rx_i;
		d.s2 = q.s1;
		l = q.s2 ^ invert_i;
		d.prev = l;
		d.valid = 1'b0;
		d.brk = 1'b0;
		unique case (q.st)
			RX_IDLE: if (q.prev && !l) begin
				d.st = RX_START;
				d.cnt = div_i >> 1;
			end
			RX_START: if (q.cnt == 16'h0000) begin
				// glitch shorter than half a bit is dropped
				d.st = l ? RX_IDLE : RX_DATA;
				d.cnt = div_i - 16'h0001;
				d.nb = 3'h0;
			end else d.cnt = q.cnt - 16'h0001;
			RX_DATA: if (q.cnt == 16'h0000) begin
				d.sh = {l, q.sh[7:1]};
				d.cnt = div_i - 16'h0001;
				d.nb = q.nb + 3'h1;
				if (q.nb == 3'h7) d.st = RX_STOP;
			end else d.cnt = q.cnt - 16'h0001;
			RX_STOP: if (q.cnt == 16'h0000) begin
				d.st = RX_IDLE;
				d.data = q.sh;
				d.valid = l;
				d.brk = !l && (q.sh == 8'h00);
			end else d.cnt = q.cnt - 16'h0001;
		endcase
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) q <= RST;
		else q <= d;
	end
	assign data_o = q.data;
	assign valid_o = q.valid;
	assign brk_o = q.brk;
endmodule : bsr_uart_rx

// ### verilog/bsr_host.sv
/*
 * host end: apb registers drive the init sequence and request pulses,
 * and catch the bytes the device sends back.
 * assumes an apb master on the same clock and a pulled-down link.
 */
`timescale 1ns/1ns
`include "bsr_regs.svh"
module bsr_host
	import bsr_pkg::*;
#(
	parameter int INIT_HOLD_CYC = `BSR_INIT_HOLD_CYC,
	parameter int SETTLE_CYC    = `BSR_SETTLE_CYC
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	bsr_link_if.host         link,
	input  wire logic [7:0]  paddr_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             irq_o
);
	localparam logic [15:0] LDIV = 16'(`BSR_LINK_DIV);
	typedef struct packed {
		bsr_host_st_t st;
		logic [23:0]  cnt;
		logic [20:0]  sh;
		logic [4:0]   nb;
		logic [15:0]  div;
		logic         oe;
		logic         out;
		logic [7:0]   cfg;
		logic [7:0]   mbyte;
		logic [7:0]   rxdata;
		logic [1:0]   irq_st;
		logic [1:0]   irq_msk;
		logic [31:0]  prdata;
		logic         pready;
		logic         pslverr;
		logic         irq;
	} bsr_host_s_t;
	localparam bsr_host_s_t RST = '{st: HS_IDLE, default: '0};
	bsr_host_s_t q, d;
	logic [7:0]  rx_data;
	logic        rx_valid;
	logic        acc;
	logic        wr;
	logic [1:0]  set;
	logic [1:0]  clr;
	////////////////////////////////////////////////////////////////////////
	bsr_uart_rx u_rx (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		// own drive masked so the host never hears its own frames
		.rx_i      (link.line && !q.oe),
		.invert_i  (1'b1), // [RL8]
		.div_i     (LDIV),
		.data_o    (rx_data),
		.valid_o   (rx_valid),
		.brk_o     ()
	);
	////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.out = 1'b1;
		set = 2'b00;
		clr = 2'b00;
		acc = psel_i && penable_i && !q.pready;
		// write lands on the edge the master sees pready high
		wr = psel_i && penable_i && q.pready && pwrite_i;
		d.pready = acc;
		d.pslverr = 1'b0;
		d.prdata = 32'h0000_0000;
		if (acc) unique case (paddr_i)
			`BSR_REG_CTRL: ;
			`BSR_REG_CFG: d.prdata = {16'h0000, q.mbyte, q.cfg};
			`BSR_REG_STAT: d.prdata = {31'h0, q.st != HS_IDLE};
			`BSR_REG_RXDATA: d.prdata = {24'h0, q.rxdata};
			`BSR_REG_IRQ_STAT: d.prdata = {30'h0, q.irq_st};
			`BSR_REG_IRQ_MASK: d.prdata = {30'h0, q.irq_msk};
			default: d.pslverr = 1'b1;
		endcase
		if (wr && paddr_i == `BSR_REG_CFG) begin
			d.cfg = pwdata_i[7:0];
			d.mbyte = pwdata_i[15:8];
		end
		if (wr && paddr_i == `BSR_REG_IRQ_STAT) clr = pwdata_i[1:0];
		if (wr && paddr_i == `BSR_REG_IRQ_MASK) d.irq_msk = pwdata_i[1:0];
		d.cnt = q.cnt + 24'h1;
		unique case (q.st)
			HS_IDLE: begin
				if (rx_valid) begin
					d.rxdata = rx_data; // [RL2]
					set[`BSR_IRQ_RX] = 1'b1;
				end
				d.cnt = 24'h0;
				// commands while busy are ignored
				if (wr && paddr_i == `BSR_REG_CTRL) begin
					if (pwdata_i[`BSR_CTRL_INIT]) d.st = HS_INIT;
					else if (pwdata_i[`BSR_CTRL_REQ]) d.st = HS_REQ;
				end
			end
			HS_INIT: if (q.cnt == 24'(INIT_HOLD_CYC - 1)) begin
				d.st = HS_SEND; // [RL13]
				d.sh = {bsr_frame(q.mbyte), bsr_frame(q.cfg), 1'b0};
				d.nb = q.cfg[`BSR_CFG_MATCH] ? 5'd20 : 5'd10;
				d.div = LDIV - 16'h0001;
			end
			HS_SEND: begin
				d.cnt = 24'h0;
				if (q.div == 16'h0000) begin
					d.div = LDIV - 16'h0001;
					d.sh = q.sh >> 1;
					d.nb = q.nb - 5'd1;
					if (q.nb == 5'd0) d.st = HS_WAIT;
				end else d.div = q.div - 16'h0001;
			end
			HS_WAIT: if (q.cnt == 24'(SETTLE_CYC - 1)) begin
				d.st = HS_IDLE; // [RL14]
				set[`BSR_IRQ_INIT] = 1'b1;
			end
			// pulse kept under half a bit so no receiver takes it as data
			HS_REQ: if (q.cnt == 24'(`BSR_REQ_PULSE_CYC - 1))
				d.st = HS_IDLE; // [RL7]
		endcase
		d.oe = (d.st == HS_INIT) || (d.st == HS_REQ) ||
		       (d.st == HS_SEND && d.sh[0]); // [RL2] [RL8]
		// a new event beats a clear in the same cycle
		d.irq_st = (q.irq_st & ~clr) | set;
		d.irq = |(d.irq_st & d.irq_msk);
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) q <= RST;
		else q <= d;
	end
	////////////////////////////////////////////////////////////////////////
	assign link.host_oe = q.oe;
	assign link.host_out = q.out;
	assign prdata_o = q.prdata;
	assign pready_o = q.pready;
	assign pslverr_o = q.pslverr;
	assign irq_o = q.irq;
endmodule : bsr_host

// ### dv/bsr_link_sva.sv
/*
 * link checker for the buffered serial receiver pair.
 * assumes one clock and the device status pins beside the link.
 */
`timescale 1ns/1ns
module bsr_link_sva #(
	parameter int INIT_HOLD_CYC = 3000
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic host_out,
	input wire logic host_oe,
	input wire logic dev_out,
	input wire logic dev_oe,
	input wire logic buf_empty_o,
	input wire logic buf_rdy_n_o
);
	localparam int BIT = 1041;
	logic [15:0] h_run_q;
	logic [15:0] d_run_q;
	logic [15:0] wait_q;
	logic        armed_q;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////////
	// run lengths; a fall shows as oe low with a nonzero run
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			h_run_q <= 16'h0000;
			d_run_q <= 16'h0000;
			wait_q  <= 16'h0000;
			armed_q <= 1'b0;
		end else begin
			h_run_q <= host_oe ? h_run_q + 16'h0001 : 16'h0000;
			d_run_q <= dev_oe ? d_run_q + 16'h0001 : 16'h0000;
			wait_q  <= armed_q ? wait_q + 16'h0001 : 16'h0000;
			if (dev_oe)
				armed_q <= 1'b0;
			else if (!host_oe && h_run_q == 16'h00C8 && !buf_empty_o)
				armed_q <= 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////////
	dev_drive_high_a: assert property (dev_oe |-> dev_out)
		else $error("device drives the link low");
	host_drive_high_a: assert property (host_oe |-> host_out)
		else $error("host drives the link low");
	no_contention_a: assert property (!(host_oe && dev_oe))
		else $error("both ends drive the link");
	dev_bit_len_a: assert property (!dev_oe && d_run_q != 0 |->
		d_run_q % BIT == 0)
		else $error("device high run not whole bits");
	dev_frame_max_a: assert property (dev_oe |-> d_run_q < 9 * BIT)
		else $error("device high run longer than a frame");
	host_pulse_len_a: assert property (!host_oe && h_run_q != 0 |->
		h_run_q == 200 || h_run_q == INIT_HOLD_CYC ||
		h_run_q % BIT == 0)
		else $error("host high run of odd length");
	reply_late_a: assert property (armed_q |-> wait_q <= 1060)
		else $error("device start bit too late");
	reply_early_a: assert property (armed_q && dev_oe |->
		wait_q >= 1035)
		else $error("device start bit too early");
	full_not_empty_a: assert property (buf_rdy_n_o |-> !buf_empty_o)
		else $error("full and empty together");
	cover property (armed_q && dev_oe);
	cover property (buf_rdy_n_o);
	cover property (!host_oe && h_run_q == INIT_HOLD_CYC);
endmodule : bsr_link_sva

// ### dv/testbench.sv
/*
 * self-checking bench: host over apb, device fed on its serial input.
 * assumes both ends on one 10 MHz clock, depth cut to 2 for run time.
 */
`timescale 1ns/1ns
`include "bsr_regs.svh"
module testbench;
	localparam int BIT = 1041;
	logic        clk, rst_n, ser_rx, psel, penable, pwrite, inv, err;
	logic [7:0]  paddr, m;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, irq, empty, rdy_n;
	logic [7:0]  b [4];
	int          error_cnt, cmp_count, seed, cyc;
	bsr_link_if link_if ();
	bsr_host #(.INIT_HOLD_CYC(3000), .SETTLE_CYC(500)) bsr_host_i (
		.clk_sys_i(clk), .rst_n_i(rst_n), .link(link_if.host),
		.paddr_i(paddr), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .irq_o(irq));
	bsr_device #(.DEPTH(2), .INIT_DET_CYC(1500)) bsr_device_i (
		.clk_sys_i(clk), .rst_n_i(rst_n), .link(link_if.dev),
		.ser_rx_i(ser_rx), .buf_empty_o(empty), .buf_rdy_n_o(rdy_n));
	bsr_link_sva #(.INIT_HOLD_CYC(3000)) bsr_link_sva_i (
		.clk_sys_i(clk), .rst_n_i(rst_n), .host_out(link_if.host_out),
		.host_oe(link_if.host_oe), .dev_out(link_if.dev_out),
		.dev_oe(link_if.dev_oe), .buf_empty_o(empty),
		.buf_rdy_n_o(rdy_n));
	always #50 clk = ~clk;
	////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	// request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic idle();
		rd = 32'h0000_0001;
		while (rd[0] !== 1'b0) apb(1'b0, `BSR_REG_STAT, 32'h0);
	endtask : idle
	// frame lsb first, flipped for an inverted input
	task automatic ser(input logic [9:0] f);
		for (int i = 0; i < 10; i++) begin
			ser_rx <= f[i] ^ inv;
			repeat (BIT) @(posedge clk);
		end
	endtask : ser
	task automatic cfg(input logic [15:0] c);
		inv = c[0];
		ser_rx <= ~c[0];
		apb(1'b1, `BSR_REG_CFG, {16'h0000, c});
		apb(1'b1, `BSR_REG_CTRL, 32'h0000_0001);
		idle();
	endtask : cfg
	task automatic get(input logic [7:0] e);
		wait (irq === 1'b1);
		@(posedge clk);
		apb(1'b0, `BSR_REG_RXDATA, 32'h0);
		chk(rd, {24'h0, e});
		apb(1'b1, `BSR_REG_IRQ_STAT, 32'h0000_0001);
	endtask : get
	////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc++;
		if (cyc == 250000) begin
			error_cnt++;
			print_verdict();
		end
	end
	initial begin
		clk = 1'b0; rst_n = 1'b0; ser_rx = 1'b1; psel = 1'b0;
		penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
		inv = 1'b0; error_cnt = 0; cmp_count = 0; seed = 50068; cyc = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({30'h0, empty, rdy_n}, 32'h2);
		apb(1'b0, 8'h3C, 32'h0);
		chk({err, rd[30:0]}, 32'h8000_0000);
		cfg(16'h0009);
		apb(1'b0, `BSR_REG_IRQ_STAT, 32'h0);
		chk({rd[31:1], irq}, 32'h2);
		apb(1'b1, `BSR_REG_IRQ_MASK, 32'h0000_0003);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, `BSR_REG_IRQ_STAT, 32'h0000_0002);
		chk({31'h0, irq}, 32'h0);
		// nothing stored yet, so a request must stay silent
		apb(1'b1, `BSR_REG_CTRL, 32'h0000_0002);
		repeat (1500) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		idle();
		for (int i = 0; i < 3; i++) begin
			b[i] = 8'($random(seed));
			ser({1'b1, b[i], 1'b0});
		end
		chk({30'h0, empty, rdy_n}, 32'h1);
		apb(1'b1, `BSR_REG_CTRL, 32'h0000_0002);
		get(b[0]);
		get(b[1]);
		repeat (12 * BIT) @(posedge clk);
		chk({29'h0, irq, empty, rdy_n}, 32'h2);
		// match after break, single byte per request
		m = 8'($random(seed));
		b[2] = 8'($random(seed));
		b[3] = 8'($random(seed));
		cfg({m, 8'h30});
		apb(1'b1, `BSR_REG_IRQ_STAT, 32'h0000_0003);
		chk({31'h0, irq}, 32'h0);
		ser({1'b1, m, 1'b0});
		ser(10'h000);
		ser_rx <= 1'b1;
		repeat (BIT) @(posedge clk);
		for (int i = 1; i < 4; i++)
			ser({1'b1, i == 1 ? m : b[i], 1'b0});
		apb(1'b1, `BSR_REG_CTRL, 32'h0000_0002);
		get(b[2]);
		repeat (12 * BIT) @(posedge clk);
		chk({30'h0, irq, empty}, 32'h0);
		apb(1'b1, `BSR_REG_CTRL, 32'h0000_0002);
		get(b[3]);
		repeat (2 * BIT) @(posedge clk);
		chk({31'h0, empty}, 32'h1);
		print_verdict();
	end
endmodule : testbench
